// ---- src/rx_desc_writeback.v ----
// Purpose: Receive descriptor fetch, frame store and status writeback.
// Assumes: Word-wide receive FIFO, word memory master with ack handshake.
// Notes:   Registers over APB; one clock, clock enable freezes all state.
`timescale 1ns/1ns
`include "rx_desc_regs.vh"

module rx_desc_writeback #(
  parameter CW = 14
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        ce,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Host memory master
  output reg         mem_req,
  output reg         mem_we,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  output reg  [3:0]  mem_be,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  // Receive FIFO
  input  wire        rx_valid,
  input  wire [31:0] rx_data,
  input  wire        rx_last,
  input  wire [1:0]  rx_last_bytes,
  output reg         rx_ready,
  // Frame status, valid with rx_last
  input  wire        st_crc_err,
  input  wire        st_align_err,
  input  wire        st_overrun,
  input  wire        st_rx_er,
  input  wire        st_no_match,
  input  wire        st_ia_match,
  input  wire [15:0] st_type_len,
  // Receive unit state
  output reg         no_resource_event,
  output reg  [3:0]  receive_unit
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_RD0  = 8'h02;
  localparam [7:0] S_RD1  = 8'h04;
  localparam [7:0] S_RD3  = 8'h08;
  localparam [7:0] S_RECV = 8'h10;
  localparam [7:0] S_DWR  = 8'h20;
  localparam [7:0] S_WB3  = 8'h40;
  localparam [7:0] S_WB0  = 8'h80;
  localparam [3:0] RU_IDLE = 4'h1;
  localparam [3:0] RU_RDY  = 4'h2;
  localparam [3:0] RU_SUSP = 4'h4;
  localparam [3:0] RU_NORES = 4'h8;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [7:0]    st_q;
  reg [31:0]   base_q, list_q, cur_q, next_q, crc_cnt_q;
  reg [CW-1:0] hds_q, size_q, cnt_q, tot_q;
  reg          hds_ok_q, save_bad_q, eol_q, susp_q, hdr_q, last_q, noroom_q;
  reg          f_crc_q, f_aln_q, f_orun_q, f_er_q, f_nom_q, f_ia_q;
  reg [15:0]   f_tl_q;
  wire [15:0]  status;

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  wire [31:0]   desc_a = base_q + cur_q;
  wire          take   = rx_valid & rx_ready;
  wire [2:0]    wbytes = (rx_last && rx_last_bytes != 2'h0) ? {1'b0, rx_last_bytes} : 3'h4;
  wire [CW-1:0] cap    = hdr_q ? hds_q : size_q;
  wire [CW-1:0] room   = cap - cnt_q;
  wire          short  = room < {{(CW-3){1'b0}}, wbytes};
  wire [2:0]    nstore = short ? room[2:0] : wbytes;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire          apb_go = psel & penable & pready;
  wire          is_ctl = apb_go & pwrite & (paddr == `OFS_CTRL);

  // ----------------------------------------
  // Status word from latched frame flags
  // ----------------------------------------
  rx_status_pack u_pack (
    .save_bad   (save_bad_q),
    .crc_err    (f_crc_q),
    .align_err  (f_aln_q),
    .overrun    (f_orun_q),
    .rx_er_seen (f_er_q),
    .no_match   (f_nom_q),
    .ia_match   (f_ia_q),
    .no_room    (noroom_q & ~hdr_q),
    .type_len   (f_tl_q),
    .total      (tot_q[13:0]),
    .status     (status)
  );

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
      base_q     <= 32'h0000_0000;
      list_q     <= 32'h0000_0000;
      hds_q      <= {CW{1'b0}};
      save_bad_q <= 1'b0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        pslverr <= 1'b0;
        case (paddr)
          `OFS_CTRL:     prdata <= {29'h0, save_bad_q, 2'h0};
          `OFS_RU_BASE:  prdata <= base_q;
          `OFS_LIST_PTR: prdata <= list_q;
          `OFS_HDR_SIZE: prdata <= {{(32-CW){1'b0}}, hds_q};
          `OFS_STATE:    prdata <= {23'h0, hds_ok_q, st_q};
          `OFS_CRC_CNT:  prdata <= crc_cnt_q;
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (apb_go && pwrite) begin
        case (paddr)
          `OFS_CTRL:     save_bad_q <= pwdata[`CTL_SAVE_BAD];
          `OFS_RU_BASE:  base_q <= pwdata;
          `OFS_LIST_PTR: list_q <= pwdata;
          `OFS_HDR_SIZE: hds_q <= pwdata[CW-1:0];
          default:       base_q <= base_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Receive unit and descriptor engine
  // ----------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q              <= S_IDLE;
      receive_unit      <= RU_IDLE;
      no_resource_event <= 1'b0;
      rx_ready          <= 1'b0;
      mem_req           <= 1'b0;
      mem_we            <= 1'b0;
      mem_addr          <= 32'h0000_0000;
      mem_wdata         <= 32'h0000_0000;
      mem_be            <= 4'h0;
      cur_q             <= 32'h0000_0000;
      next_q            <= 32'h0000_0000;
      crc_cnt_q         <= 32'h0000_0000;
      size_q            <= {CW{1'b0}};
      cnt_q             <= {CW{1'b0}};
      tot_q             <= {CW{1'b0}};
      hds_ok_q          <= 1'b0;
      eol_q             <= 1'b0;
      susp_q            <= 1'b0;
      hdr_q             <= 1'b0;
      last_q            <= 1'b0;
      noroom_q          <= 1'b0;
      f_crc_q           <= 1'b0;
      f_aln_q           <= 1'b0;
      f_orun_q          <= 1'b0;
      f_er_q            <= 1'b0;
      f_nom_q           <= 1'b0;
      f_ia_q            <= 1'b0;
      f_tl_q            <= 16'h0000;
    end else if (ce) begin
      no_resource_event <= 1'b0;
      if (is_ctl && pwdata[`CTL_LOAD_HDR])
        hds_ok_q <= 1'b1;
      if (is_ctl && pwdata[`CTL_RESUME] && receive_unit == RU_SUSP)
        receive_unit <= RU_RDY;
      // Restart only from an idle engine so a frame in flight is not torn
      if (is_ctl && pwdata[`CTL_START] && st_q == S_IDLE) begin
        cur_q        <= list_q;
        receive_unit <= RU_RDY;
      end
      case (st_q)
        S_IDLE: begin
          // Frames arriving without a ready unit are drained and dropped
          rx_ready <= (receive_unit != RU_RDY);
          if (receive_unit == RU_RDY && !(is_ctl && pwdata[`CTL_START])) begin
            rx_ready <= 1'b0;
            st_q     <= S_RD0;
          end
        end
        S_RD0: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= desc_a;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            eol_q   <= mem_rdata[`B_EOL];
            susp_q  <= mem_rdata[`B_SUSP];
            hdr_q   <= mem_rdata[`B_HDR] & hds_ok_q;
            st_q    <= S_RD1;
          end
        end
        S_RD1: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_addr <= desc_a + `DW_LINK;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            next_q  <= mem_rdata;
            st_q    <= S_RD3;
          end
        end
        S_RD3: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_addr <= desc_a + `DW_COUNT;
          end else if (mem_ack) begin
            mem_req  <= 1'b0;
            size_q   <= mem_rdata[`SIZE_HI:`SIZE_LO];
            cnt_q    <= {CW{1'b0}};
            tot_q    <= {CW{1'b0}};
            noroom_q <= 1'b0;
            rx_ready <= 1'b1;
            st_q     <= S_RECV;
          end
        end
        S_RECV: begin
          if (take) begin
            tot_q  <= tot_q + {{(CW-3){1'b0}}, wbytes};
            last_q <= rx_last;
            if (short)
              noroom_q <= 1'b1;
            if (rx_last) begin
              f_crc_q  <= st_crc_err;
              f_aln_q  <= st_align_err;
              f_orun_q <= st_overrun;
              f_er_q   <= st_rx_er;
              f_nom_q  <= st_no_match;
              f_ia_q   <= st_ia_match;
              f_tl_q   <= st_type_len;
            end
            if (nstore != 3'h0) begin
              rx_ready  <= 1'b0;
              mem_req   <= 1'b1;
              mem_we    <= 1'b1;
              mem_addr  <= desc_a + `DW_DATA + {{(32-CW){1'b0}}, cnt_q[CW-1:2], 2'b00};
              mem_wdata <= rx_data;
              mem_be    <= (4'h1 << nstore) - 4'h1;
              cnt_q     <= cnt_q + {{(CW-3){1'b0}}, nstore};
              st_q      <= S_DWR;
            end else if (rx_last) begin
              // Overflowing tail is swallowed without memory traffic
              rx_ready <= 1'b0;
              st_q     <= S_WB3;
            end
          end
        end
        S_DWR: begin
          if (mem_ack) begin
            mem_req  <= 1'b0;
            rx_ready <= ~last_q;
            st_q     <= last_q ? S_WB3 : S_RECV;
          end
        end
        S_WB3: begin
          if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= desc_a + `DW_COUNT;
            // Size half untouched; header overflow leaves data unfinished
            mem_be    <= `HALF_BE;
            mem_wdata <= {16'h0000, ~(hdr_q & noroom_q), 1'b1,
                          cnt_q[13:0]};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            st_q    <= S_WB0;
          end
        end
        S_WB0: begin
          if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_addr  <= desc_a;
            mem_be    <= `HALF_BE;
            mem_wdata <= {16'h0000, status};
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            cur_q   <= next_q;
            if (save_bad_q && f_er_q)
              crc_cnt_q <= crc_cnt_q + 32'h0000_0001;
            if (eol_q) begin
              receive_unit      <= RU_NORES;
              no_resource_event <= 1'b1;
            end else if (susp_q)
              receive_unit <= RU_SUSP;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

endmodule // rx_desc_writeback

// ---- src/rx_desc_regs.vh ----
// Purpose: Register map, descriptor layout and limits of the receive
//          descriptor writeback engine.
// Assumes: Included by its bare name.
// Notes:   Offsets are APB byte addresses.
`ifndef RX_DESC_REGS_VH
`define RX_DESC_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CTRL      8'h00
`define OFS_RU_BASE   8'h04
`define OFS_LIST_PTR  8'h08
`define OFS_HDR_SIZE  8'h0C
`define OFS_STATE     8'h10
`define OFS_CRC_CNT   8'h14

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTL_START     0
`define CTL_RESUME    1
`define CTL_SAVE_BAD  2
`define CTL_LOAD_HDR  3

// ----------------------------------------
// Descriptor words and fields
// ----------------------------------------
`define DW_LINK       32'h0000_0004
`define DW_COUNT      32'h0000_000C
`define DW_DATA       32'h0000_0010
`define B_EOL         31
`define B_SUSP        30
`define B_HDR         20
`define B_DONE        15
`define B_OK          13
`define B_CRC         11
`define B_ALIGN       10
`define B_NOROOM      9
`define B_ORUN        8
`define B_SHORT       7
`define B_TYPE        5
`define B_RXER        4
`define B_NOMATCH     2
`define B_NOTIA       1
`define B_EOD         15
`define B_CVALID      14
`define SIZE_HI       29
`define SIZE_LO       16
`define HALF_BE       4'h3

// ----------------------------------------
// Frame limits and reset values
// ----------------------------------------
`define MIN_FRAME     14'h0040
`define MAX_LEN       16'h05DC
`define CTRL_RST      32'h0000_0000

`endif

// ---- src/rx_status_pack.v ----
// Purpose: Builds the 16-bit descriptor status word of one frame.
// Assumes: Inputs stable while the status word is written.
// Notes:   Pure combinational.
`timescale 1ns/1ns
`include "rx_desc_regs.vh"

module rx_status_pack (
  // Frame outcome
  input  wire        save_bad,
  input  wire        crc_err,
  input  wire        align_err,
  input  wire        overrun,
  input  wire        rx_er_seen,
  input  wire        no_match,
  input  wire        ia_match,
  input  wire        no_room,
  input  wire [15:0] type_len,
  input  wire [13:0] total,
  // Packed word
  output reg  [15:0] status
);

  reg bad;

  always @* begin
    status = 16'h0000;
    status[`B_DONE]    = 1'b1;
    status[`B_CRC]     = save_bad & crc_err;
    status[`B_ALIGN]   = save_bad & align_err;
    status[`B_NOROOM]  = no_room;
    status[`B_ORUN]    = save_bad & overrun;
    status[`B_SHORT]   = save_bad & (total < `MIN_FRAME);
    status[`B_TYPE]    = (type_len == 16'h0000) | (type_len > `MAX_LEN);
    status[`B_RXER]    = save_bad & rx_er_seen;
    status[`B_NOMATCH] = no_match;
    status[`B_NOTIA]   = ~ia_match;
    // Bits 12, 6, 3 stay zero
    bad = crc_err | align_err | overrun | rx_er_seen | (total < `MIN_FRAME);
    status[`B_OK]      = ~bad & ~no_room;
  end

endmodule // rx_status_pack

// ---- sim/rx_wb_props.sv ----
// Purpose: Port-level checks of the receive descriptor writeback engine.
// Assumes: One clock domain, async active-high reset.
// Notes:   Status writes use half-word enables at descriptor offset 0.
`timescale 1ns/1ns
module rx_wb_props (
  // Clock and reset
  input wire        clk_sys,
  input wire        rst,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  // Memory master
  input wire        mem_req,
  input wire        mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [3:0]  mem_be,
  input wire        mem_ack,
  // Receive side
  input wire        rx_valid,
  input wire        rx_ready,
  input wire        no_resource_event,
  input wire [3:0]  receive_unit
);
  // ----------------------------------------
  // Helpers and assertions
  // ----------------------------------------
  // Descriptors need not be 16-byte aligned, so track the fetched base
  logic [31:0] desc_q;
  logic [1:0]  rd_n;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      desc_q <= 32'h0000_0000;
      rd_n   <= 2'h0;
    end else if (mem_req && !mem_we && mem_ack) begin
      if (rd_n == 2'h0)
        desc_q <= mem_addr;
      rd_n <= (rd_n == 2'h2) ? 2'h0 : rd_n + 2'h1;
    end
  end
  wire hw_wr  = mem_req && mem_we && mem_be == 4'h3;
  wire st_wr  = hw_wr && mem_addr == desc_q;
  wire cnt_wr = hw_wr && mem_addr == desc_q + 32'h0000_000C;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_DONE_BIT:
    assert property (st_wr |-> mem_wdata[15]) else $error("status write without done bit");
  AST_OK_CLEAN:
    assert property (st_wr && mem_wdata[13] |-> mem_wdata[11:7] == 5'h00 && !mem_wdata[4])
      else $error("ok bit beside an error bit");
  AST_RSVD_ZERO:
    assert property (st_wr |-> !mem_wdata[12] && !mem_wdata[6] && !mem_wdata[3])
      else $error("reserved status bit set");
  AST_CNT_VALID:
    assert property (cnt_wr |-> mem_wdata[14]) else $error("count written without valid flag");
  AST_NORES_STATE:
    assert property (no_resource_event |-> ##[0:1] receive_unit == 4'h8)
      else $error("no-resource pulse without state");
  AST_NORES_PULSE:
    assert property (no_resource_event |=> !no_resource_event) else $error("pulse too long");
  AST_DISCARD:
    assert property (receive_unit == 4'h8 && rx_valid && rx_ready |=> !(mem_req && mem_we) [*4])
      else $error("frame stored while out of resources");
  AST_ONE_STATE:
    assert property ($onehot(receive_unit)) else $error("unit state not one-hot");
  AST_REQ_HOLD:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_be)
      && $stable(mem_wdata) && $stable(mem_we)) else $error("memory request changed");
  AST_REQ_DROP:
    assert property (mem_req && mem_ack |=> !mem_req) else $error("request held after ack");
  AST_APB_WAIT:
    assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("apb wait");
  AST_APB_ERR:
    assert property (pready && pslverr |-> prdata == 32'h0) else $error("error read not zero");

  CV_NORES: cover property (no_resource_event);
  CV_SUSP:  cover property (receive_unit == 4'h4);
  CV_ERR:   cover property (pready && pslverr);
endmodule // rx_wb_props

// ---- sim/host_mem_model.sv ----
// Purpose: Host memory answering the engine's word requests.
// Assumes: Requests held until ack.
// Notes:   Latency rotates 1..4 cycles, prompt and slow.
`timescale 1ns/1ns
module host_mem_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Memory port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [3:0]  mem_be,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  logic [31:0] ram [0:1023];
  logic [1:0]  wait_q;
  logic [1:0]  lat_q;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      lat_q <= 2'h0;
      mem_rdata <= 32'hA5A5_A5A5;
    end else if (mem_req && !mem_ack) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q >= lat_q) begin
        mem_ack <= 1'b1;
        wait_q <= 2'h0;
        lat_q <= lat_q + 2'h1;
        mem_rdata <= ram[mem_addr[11:2]];
        for (int b = 0; b < 4; b++)
          if (mem_we && mem_be[b]) ram[mem_addr[11:2]][8*b+:8] <= mem_wdata[8*b+:8];
      end
    end else begin
      mem_ack <= 1'b0;
      // Stale data flips so nobody can lean on it
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // host_mem_model

// ---- sim/rx_frame_descriptor_writeback_tb.sv ----
// Purpose: Self-checking bench of the receive descriptor writeback engine.
// Assumes: Descriptors preloaded in host memory before start.
// Notes:   Suspend, resume, overflow, no-resource, discard, header, APB errors.
`timescale 1ns/1ns
module rx_frame_descriptor_writeback_tb;
  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
  logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        rx_valid = 1'b0, rx_last = 1'b0, nre_seen = 1'b0;
  logic        pready, pslverr, mem_req, mem_we, mem_ack, rx_ready, nre;
  logic [1:0]  rx_last_bytes = 2'h0;
  logic [3:0]  mem_be, receive_unit;
  logic [5:0]  st = 6'h00;
  logic [7:0]  paddr = 8'h00;
  logic [15:0] tl = 16'h0000;
  logic [31:0] pwdata = 32'h0, rx_data = 32'h0, prdata, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] seed = 32'h0000_0044;
  logic [32:0] er;
  logic [67:0] ew;
  logic [32:0] rq[$];
  logic [67:0] wq[$];
  int          error_cnt = 0, num_checks = 0;
  wire  [31:0] be_mask = {{8{mem_be[3]}}, {8{mem_be[2]}}, {8{mem_be[1]}}, {8{mem_be[0]}}};

  rx_desc_writeback dut_u (.clk_sys, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be,
    .mem_ack, .mem_rdata, .rx_valid, .rx_data, .rx_last, .rx_last_bytes, .rx_ready,
    .st_crc_err(st[0]), .st_align_err(st[1]), .st_overrun(st[2]), .st_rx_er(st[3]),
    .st_no_match(st[4]), .st_ia_match(st[5]), .st_type_len(tl), .no_resource_event(nre),
    .receive_unit);
  host_mem_model mem_u (.clk_sys, .rst, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be,
    .mem_ack, .mem_rdata);

  initial forever #20 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    if (!w) rq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Sends n words, the first nw of which should land at a
  task automatic send(input int n, input int nw, input logic [31:0] a, input logic [1:0] lb);
    logic [31:0] d;
    for (int k = 0; k < n; k++) begin
      d = xs();
      rx_valid <= 1'b1;
      rx_data <= d;
      rx_last <= (k == n - 1);
      rx_last_bytes <= lb;
      if (k < nw) wq.push_back({a + 32'(4 * k), d, 4'hF});
      do @(posedge clk_sys); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask

  task automatic wait_ru(input logic [3:0] v);
    int t;
    t = 0;
    while (receive_unit !== v && t++ < 500) @(posedge clk_sys);
    `CHK(receive_unit, v)
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Monitor and sequence
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (nre === 1'b1) nre_seen <= 1'b1;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      er = rq.size() ? rq.pop_front() : {33{1'bx}};
      `CHK({pslverr, prdata}, er)
    end
    if (mem_req === 1'b1 && mem_we && mem_ack === 1'b1) begin
      ew = wq.size() ? wq.pop_front() : {68{1'bx}};
      `CHK({mem_addr, mem_wdata & be_mask, mem_be}, ew)
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end

  initial begin
    // Suspend flag, link to the second descriptor, size 64, done flags clear, model select 0
    // Header flag set but ignored until a header size load
    mem_u.ram[8'h40] = 32'h4010_0000;
    mem_u.ram[8'h41] = 32'h0000_0180;
    mem_u.ram[8'h42] = 32'h5A5A_5A5A;
    mem_u.ram[8'h43] = 32'h0040_0000;
    mem_u.ram[8'h80] = 32'h8000_0000;
    mem_u.ram[8'h81] = 32'h0000_0000;
    mem_u.ram[8'h83] = 32'h0004_0000;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b1, 8'h04, 32'h80, 33'h0);
    apb(1'b1, 8'h08, 32'h80, 33'h0);
    apb(1'b0, 8'h04, 32'h0, 33'h80);
    apb(1'b1, 8'h00, 32'h1, 33'h0);
    wait_ru(4'h2);
    st <= 6'h20;
    tl <= 16'h0800;
    send(16, 16, 32'h110, 2'h0);
    wq.push_back({32'h10C, 32'h0000_C040, 4'h3});
    wq.push_back({32'h100, 32'h0000_A020, 4'h3});
    wait_ru(4'h4);
    st <= 6'h19;
    tl <= 16'h0100;
    apb(1'b1, 8'h00, 32'h6, 33'h0);
    wait_ru(4'h2);
    send(3, 1, 32'h210, 2'h2);
    wq.push_back({32'h20C, 32'h0000_C004, 4'h3});
    wq.push_back({32'h200, 32'h0000_8A96, 4'h3});
    wait_ru(4'h8);
    send(2, 0, 32'h0, 2'h0);
    repeat (20) @(posedge clk_sys);
    `CHK(nre_seen, 1'b1)
    // Header descriptor: size load, then restart on the first descriptor
    mem_u.ram[8'h43] = 32'h0040_0000;
    st <= 6'h20;
    tl <= 16'h05DC;
    apb(1'b1, 8'h0C, 32'h8, 33'h0);
    apb(1'b1, 8'h00, 32'hD, 33'h0);
    wait_ru(4'h2);
    send(4, 2, 32'h110, 2'h0);
    wq.push_back({32'h10C, 32'h0000_4008, 4'h3});
    wq.push_back({32'h100, 32'h0000_8080, 4'h3});
    wait_ru(4'h4);
    apb(1'b0, 8'h14, 32'h0, 33'h1);
    apb(1'b0, 8'h00, 32'h0, 33'h4);
    apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
    `CHK(mem_u.ram[8'h42], 32'h5A5A_5A5A)
    `CHK(wq.size(), 0)
    stop_test();
  end
endmodule // rx_frame_descriptor_writeback_tb

bind rx_desc_writeback rx_wb_props chk_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
  .mem_ack(mem_ack), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .no_resource_event(no_resource_event), .receive_unit(receive_unit));
